// ===== verilog/serial_config_command_port.sv
// serial command port with register file, memory copy engine and bus
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_defines.svh"
module serial_config_command_port
	import serial_port_pkg::*;
#(
	parameter int NUM_REGS = 16,
	parameter int IDLE_TIMEOUT = `IDLE_TIMEOUT_CYCLES,
	parameter int WORD_CYCLES = `NVM_WORD_CYCLES
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic speed_command_pin,
	input wire logic speed_feedback_pin_i,
	output logic speed_feedback_pin_o,
	output logic speed_feedback_pin_oe,
	output logic alert_pin,
	output logic motor_enable,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	localparam int IW = $clog2(NUM_REGS);
	// synchroniser stages for serial clock and data
	logic sck_s1_reg, sck_s2_reg, sck_s3_reg, sdi_s1_reg, sdi_s2_reg;
	logic sck_rise, sck_fall, link_free, timeout_hit;
	// frame state
	phase_e phase_reg, phase_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [15:0] rx_reg, rx_next, tx_reg, tx_next;
	logic [15:0] rx_shift;
	logic [7:0] addr_reg, addr_next;
	logic reg_wr_reg, reg_wr_next;
	logic sdo_reg, sdo_next;
	logic drive_out_reg, drive_out_next;
	logic serial_mode_reg, serial_mode_next;
	logic [3:1] stat_reg, stat_next;
	logic [15:0] idle_cnt_reg, idle_cnt_next;
	logic frame_done, enb_after;
	logic [7:0] status_view;
	// register file and non-volatile store
	logic [15:0] normal_reg [NUM_REGS];
	logic [15:0] normal_next [NUM_REGS];
	logic [15:0] mem_reg [NUM_REGS];
	logic [15:0] mem_next [NUM_REGS];
	mem_op_e mem_op_reg, mem_op_next;
	logic [IW-1:0] mem_ptr_reg, mem_ptr_next;
	logic [7:0] mem_wait_reg, mem_wait_next;
	// bus side state
	logic [3:0] ctrl_reg, ctrl_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic cmd_end;
	logic fb_normal_drive;

	// two flip-flop synchronisers plus edge history
	always_ff @(posedge clk)
	begin
		sck_s1_reg <= speed_command_pin;
		sck_s2_reg <= sck_s1_reg;
		sck_s3_reg <= sck_s2_reg;
		sdi_s1_reg <= speed_feedback_pin_i;
		sdi_s2_reg <= sdi_s1_reg;
	end

	assign sck_rise = sck_s2_reg & ~sck_s3_reg;
	assign sck_fall = ~sck_s2_reg & sck_s3_reg;
	// feedback pin driven by normal-mode output, which blocks the link
	assign fb_normal_drive = ~serial_mode_reg & ctrl_reg[`CTRL_FB_EN_BIT];
	assign link_free = ~fb_normal_drive;
	assign timeout_hit = idle_cnt_reg >= 16'(IDLE_TIMEOUT - 1);
	assign rx_shift = {rx_reg[14:0], sdi_s2_reg};
	assign cmd_end = sck_rise & link_free & ~timeout_hit
		& (phase_reg == PH_CMD) & (bit_cnt_reg == 4'h7);
	// busy while a register transfer or memory copy runs
	assign status_view = {4'h0, stat_reg,
		(phase_reg == PH_ADDR) | (phase_reg == PH_REG_OUT)
		| (phase_reg == PH_REG_IN) | (mem_op_reg != MOP_IDLE)};

	// next state for the frame engine and storage
	always_comb
	begin
		phase_next = phase_reg;
		bit_cnt_next = bit_cnt_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		addr_next = addr_reg;
		reg_wr_next = reg_wr_reg;
		sdo_next = sdo_reg;
		drive_out_next = drive_out_reg;
		serial_mode_next = serial_mode_reg;
		stat_next = stat_reg;
		normal_next = normal_reg;
		mem_next = mem_reg;
		mem_op_next = mem_op_reg;
		mem_ptr_next = mem_ptr_reg;
		mem_wait_next = mem_wait_reg;
		frame_done = 1'b0;
		enb_after = stat_reg[`SR_ENB_BIT];
		// idle watchdog restarts on any serial clock edge
		if (sck_rise | sck_fall)
			idle_cnt_next = 16'h0000;
		else if (!timeout_hit)
			idle_cnt_next = idle_cnt_reg + 16'h0001;
		else
			idle_cnt_next = idle_cnt_reg;
		// memory copy engine, one word per WORD_CYCLES
		if (mem_op_reg != MOP_IDLE)
		begin
			if (mem_wait_reg == 8'h00)
			begin
				if (mem_op_reg == MOP_LOAD)
					normal_next[mem_ptr_reg] = mem_reg[mem_ptr_reg];
				else
					mem_next[mem_ptr_reg] = normal_reg[mem_ptr_reg];
				mem_wait_next = 8'(WORD_CYCLES - 1);
				mem_ptr_next = mem_ptr_reg + 1'b1;
				if (mem_ptr_reg == IW'(NUM_REGS - 1))
					mem_op_next = MOP_IDLE;
			end
			else
				mem_wait_next = mem_wait_reg - 8'h01;
		end
		// output bit changes on the falling serial clock edge
		if (sck_fall && drive_out_reg)
			sdo_next = tx_reg[15];
		if (timeout_hit && (phase_reg != PH_CMD || bit_cnt_reg != 4'h0))
		begin
			// stalled frame: drop it and resynchronise
			frame_done = 1'b1;
		end
		else if (sck_rise && link_free)
		begin
			rx_next = rx_shift;
			bit_cnt_next = bit_cnt_reg + 4'h1;
			if (drive_out_reg)
				tx_next = {tx_reg[14:0], 1'b0};
			case (phase_reg)
				PH_CMD:
				begin
					if (bit_cnt_reg == 4'h7)
					begin
						bit_cnt_next = 4'h0;
						if (rx_shift[7:0] == `STATUS_READ_CMD)
						begin
							serial_mode_next = 1'b1;
							phase_next = PH_STAT_OUT;
							tx_next = {status_view, 8'h00};
							drive_out_next = 1'b1;
						end
						else if (rx_shift[7:0] == `STATUS_WRITE_CMD)
						begin
							serial_mode_next = 1'b1;
							phase_next = PH_STAT_IN;
						end
						else if (!stat_reg[`SR_ENB_BIT])
						begin
							// locked out or unknown: nothing changes
							phase_next = PH_CMD;
						end
						else if (rx_shift[7:0] == `REG_READ_CMD
							|| rx_shift[7:0] == `REG_WRITE_CMD)
						begin
							serial_mode_next = 1'b1;
							phase_next = PH_ADDR;
							reg_wr_next = rx_shift[1];
						end
						else if (rx_shift[7:0] == `MEMORY_LOAD_CMD)
						begin
							serial_mode_next = 1'b1;
							if (!stat_reg[`SR_NVMWR_BIT]
								&& mem_op_reg == MOP_IDLE)
							begin
								mem_op_next = MOP_LOAD;
								mem_ptr_next = '0;
								mem_wait_next = 8'h00;
							end
						end
						else if (rx_shift[7:0] == `MEMORY_STORE_CMD)
						begin
							serial_mode_next = 1'b1;
							if (stat_reg[`SR_NVMWR_BIT]
								&& mem_op_reg == MOP_IDLE)
							begin
								mem_op_next = MOP_STORE;
								mem_ptr_next = '0;
								mem_wait_next = 8'h00;
							end
						end
						else if (rx_shift[7:0] == `MEMORY_WRITE_CANCEL_CMD)
						begin
							serial_mode_next = 1'b1;
							if (mem_op_reg == MOP_STORE)
								mem_op_next = MOP_IDLE;
						end
					end
				end
				PH_STAT_OUT:
				begin
					if (bit_cnt_reg == 4'h7)
						frame_done = 1'b1;
				end
				PH_STAT_IN:
				begin
					if (bit_cnt_reg == 4'h7)
					begin
						// busy bit is read only
						stat_next = rx_shift[3:1];
						enb_after = rx_shift[`SR_ENB_BIT];
						frame_done = 1'b1;
					end
				end
				PH_ADDR:
				begin
					if (bit_cnt_reg == 4'h7)
					begin
						bit_cnt_next = 4'h0;
						addr_next = rx_shift[7:0];
						if (reg_wr_reg)
							phase_next = PH_REG_IN;
						else
						begin
							// out of range addresses read zero
							phase_next = PH_REG_OUT;
							drive_out_next = 1'b1;
							tx_next = (rx_shift[7:0] < 8'(NUM_REGS))
								? normal_reg[rx_shift[IW-1:0]] : 16'h0000;
						end
					end
				end
				PH_REG_OUT:
				begin
					if (bit_cnt_reg == 4'hf)
						frame_done = 1'b1;
				end
				PH_REG_IN:
				begin
					if (bit_cnt_reg == 4'hf)
					begin
						if (addr_reg < 8'(NUM_REGS))
							normal_next[addr_reg[IW-1:0]] = rx_shift;
						frame_done = 1'b1;
					end
				end
				default:
					phase_next = PH_CMD;
			endcase
		end
		// end of frame: mode follows the serial enable bit
		if (frame_done)
		begin
			phase_next = PH_CMD;
			bit_cnt_next = 4'h0;
			drive_out_next = 1'b0;
			serial_mode_next = enb_after;
		end
	end

	// frame engine and storage registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_reg <= PH_CMD;
			bit_cnt_reg <= 4'h0;
			rx_reg <= 16'h0000;
			tx_reg <= 16'h0000;
			addr_reg <= 8'h00;
			reg_wr_reg <= 1'b0;
			sdo_reg <= 1'b0;
			drive_out_reg <= 1'b0;
			serial_mode_reg <= 1'b0;
			stat_reg <= 3'(`SR_RESET >> `SR_ENB_BIT);
			idle_cnt_reg <= 16'h0000;
			mem_op_reg <= MOP_IDLE;
			mem_ptr_reg <= '0;
			mem_wait_reg <= 8'h00;
			normal_reg <= '{default: 16'h0000};
			mem_reg <= '{default: 16'h0000};
		end
		else
		begin
			phase_reg <= phase_next;
			bit_cnt_reg <= bit_cnt_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			addr_reg <= addr_next;
			reg_wr_reg <= reg_wr_next;
			sdo_reg <= sdo_next;
			drive_out_reg <= drive_out_next;
			serial_mode_reg <= serial_mode_next;
			stat_reg <= stat_next;
			idle_cnt_reg <= idle_cnt_next;
			mem_op_reg <= mem_op_next;
			mem_ptr_reg <= mem_ptr_next;
			mem_wait_reg <= mem_wait_next;
			normal_reg <= normal_next;
			mem_reg <= mem_next;
		end
	end

	// next state for the bus slave, one wait cycle per access
	always_comb
	begin
		ctrl_next = ctrl_reg;
		rdata_next = rdata_reg;
		ack_next = (avs_read | avs_write) & ~ack_reg;
		if (avs_read && !ack_reg)
		begin
			if (avs_address == `CTRL_OFFSET)
				rdata_next = {28'h0, ctrl_reg};
			else if (avs_address == `STATE_OFFSET)
				rdata_next = {22'h0, link_free, serial_mode_reg,
					status_view};
			else
				rdata_next = 32'h0; // unmapped reads zero
		end
		if (avs_write && ack_reg && avs_address == `CTRL_OFFSET)
			ctrl_next = avs_writedata[3:0];
	end

	// bus slave registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_reg <= `CTRL_RESET;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign avs_readdata = rdata_reg;
	// motor runs only in normal mode
	assign motor_enable = ctrl_reg[`CTRL_RUN_BIT] & ~serial_mode_reg;
	// two-wire data out on feedback pin, else floating in serial mode
	assign speed_feedback_pin_oe = fb_normal_drive
		| (serial_mode_reg & stat_reg[`SR_WIRE_BIT] & drive_out_reg);
	assign speed_feedback_pin_o = serial_mode_reg ? sdo_reg
		: ctrl_reg[`CTRL_FB_LVL_BIT];
	// three-wire data out on alert pin
	assign alert_pin = serial_mode_reg
		? (~stat_reg[`SR_WIRE_BIT] & drive_out_reg & sdo_reg)
		: ctrl_reg[`CTRL_ALERT_BIT];

	// assertions
	sequence s_cmd(logic [7:0] code);
		cmd_end && rx_shift[7:0] == code;
	endsequence
	property p_motor_off;
		@(posedge clk) disable iff (rst) serial_mode_reg |-> !motor_enable;
	endproperty
	a_motor_off: assert property (p_motor_off)
		else $error("motor driven in serial mode");
	property p_fb_float;
		@(posedge clk) disable iff (rst)
		serial_mode_reg && !drive_out_reg |-> !speed_feedback_pin_oe;
	endproperty
	a_fb_float: assert property (p_fb_float)
		else $error("feedback pin driven in serial mode");
	property p_enter;
		@(posedge clk) disable iff (rst)
		s_cmd(`STATUS_READ_CMD) |=> serial_mode_reg && drive_out_reg
			&& phase_reg == PH_STAT_OUT;
	endproperty
	a_enter: assert property (p_enter)
		else $error("status read did not enter serial mode");
	property p_blocked;
		@(posedge clk) disable iff (rst)
		sck_rise && !link_free && !timeout_hit |=> $stable(bit_cnt_reg)
			&& $stable(rx_reg);
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("bit taken while feedback pin driven");
	property p_return;
		@(posedge clk) disable iff (rst)
		frame_done && !enb_after |=> !serial_mode_reg [*2];
	endproperty
	a_return: assert property (p_return)
		else $error("did not return to normal mode");
	property p_stay;
		@(posedge clk) disable iff (rst)
		frame_done && enb_after |=> serial_mode_reg && phase_reg == PH_CMD;
	endproperty
	a_stay: assert property (p_stay)
		else $error("left serial mode with enable set");
	property p_locked;
		@(posedge clk) disable iff (rst)
		s_cmd(`REG_WRITE_CMD) && !stat_reg[`SR_ENB_BIT]
			|=> phase_reg == PH_CMD && $stable(serial_mode_reg);
	endproperty
	a_locked: assert property (p_locked)
		else $error("register command taken while locked");
	property p_busy;
		@(posedge clk) disable iff (rst)
		phase_reg == PH_REG_IN || mem_op_reg != MOP_IDLE
			|-> status_view[`SR_BUSY_BIT];
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy bit low during work");
	property p_load_gate;
		@(posedge clk) disable iff (rst)
		s_cmd(`MEMORY_LOAD_CMD) && stat_reg[`SR_NVMWR_BIT]
			|=> $stable(mem_op_reg);
	endproperty
	a_load_gate: assert property (p_load_gate)
		else $error("load started in write mode");
	property p_cancel;
		@(posedge clk) disable iff (rst)
		s_cmd(`MEMORY_WRITE_CANCEL_CMD) && mem_op_reg == MOP_STORE
			&& stat_reg[`SR_ENB_BIT] |=> mem_op_reg == MOP_IDLE;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("store not cancelled");
	property p_stat_wr;
		@(posedge clk) disable iff (rst)
		sck_rise && link_free && !timeout_hit && phase_reg == PH_STAT_IN
			&& bit_cnt_reg == 4'h7 |=> stat_reg == $past(rx_shift[3:1]);
	endproperty
	a_stat_wr: assert property (p_stat_wr)
		else $error("status byte not stored");
endmodule : serial_config_command_port
`default_nettype wire

// ===== verilog/serial_port_defines.svh
// constants for the serial command port of the motor pre-driver
// Functional notes
// - commands accepted only while feedback pin floats
// - valid command code enters serial mode
// - motor drive stops in serial mode
// - feedback pin held floating in serial mode except two-wire data out
// - serial enable 0 returns to normal mode
// - serial enable 1 stays in serial mode
// - status read code returns eight status bits
// - status write code stores bits 3:1 of eight following bits
// - register read takes address, returns sixteen bits
// - register write takes address then sixteen bits
// - load code copies memory into registers
// - store code copies registers into memory
// - cancel code ends memory write in progress
// - serial enable 0 allows only status commands
// - wire mode bit selects three or two wire
// - busy bit shows register or memory work
// - memory mode bit gates memory reads, writes
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
// status byte fields
`define SR_BUSY_BIT 0
`define SR_ENB_BIT 1
`define SR_WIRE_BIT 2
`define SR_NVMWR_BIT 3
`define SR_RESET 8'h00
// command codes
`define STATUS_READ_CMD 8'h49
`define STATUS_WRITE_CMD 8'h4a
`define REG_READ_CMD 8'h51
`define REG_WRITE_CMD 8'h52
`define MEMORY_LOAD_CMD 8'h59
`define MEMORY_STORE_CMD 8'h5a
`define MEMORY_WRITE_CANCEL_CMD 8'h5c
// bus register byte offsets
`define CTRL_OFFSET 4'h0
`define STATE_OFFSET 4'h4
// control register fields
`define CTRL_RUN_BIT 0
`define CTRL_FB_EN_BIT 1
`define CTRL_FB_LVL_BIT 2
`define CTRL_ALERT_BIT 3
`define CTRL_RESET 4'h0
// timing counts in clock cycles
`define IDLE_TIMEOUT_CYCLES 4000
`define NVM_WORD_CYCLES 4
`endif

// ===== verilog/serial_port_pkg.sv
// types for the serial command port
`default_nettype none
package serial_port_pkg;
	// serial frame phase
	typedef enum logic [2:0] {PH_CMD, PH_STAT_OUT, PH_STAT_IN, PH_ADDR,
		PH_REG_OUT, PH_REG_IN} phase_e;
	// memory copy engine operation
	typedef enum logic [1:0] {MOP_IDLE, MOP_LOAD, MOP_STORE} mem_op_e;
endpackage : serial_port_pkg
`default_nettype wire

// ===== test/host_model.sv
// host side model that clocks serial frames into the port (3-wire)
`timescale 1ns/10ps
`default_nettype none
module host_model
(
	input wire logic clk,
	input wire logic alert_pin,
	output logic sck,
	output logic sd
);
	// link clock stands low between frames
	initial
	begin
		sck = 1'b0;
		sd = 1'b0;
	end

	// shift nout bits out msb first, then clock nin bits back in
	task automatic frame(input logic [31:0] v, input int nout,
		input int nin, output logic [31:0] r);
		int i;
		r = '0;
		for (i = 0; i < nout + nin; i++)
		begin
			if (i < nout)
				sd <= v[nout - 1 - i];
			repeat (4) @(posedge clk);
			r = {r[30:0], alert_pin}; // sampled as the clock rises
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			sck <= 1'b0;
		end
		// released data line toggles so stale bits never look valid
		sd <= ~sd;
		repeat (4) @(posedge clk);
	endtask : frame
endmodule : host_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the serial command port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk, rst; // clock and reset
	logic sck, host_sd, fb_o, fb_oe, alert_pin, motor_enable;
	wire logic fb_level; // resolved feedback pin
	logic [3:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, q;
	int n_errors, n_tests, cycles;

	// device drive wins, else host level
	assign fb_level = fb_oe ? fb_o : host_sd;

	serial_config_command_port #(.NUM_REGS(16), .IDLE_TIMEOUT(200),
		.WORD_CYCLES(2)) uut (.clk(clk), .rst(rst),
		.speed_command_pin(sck), .speed_feedback_pin_i(fb_level),
		.speed_feedback_pin_o(fb_o), .speed_feedback_pin_oe(fb_oe),
		.alert_pin(alert_pin), .motor_enable(motor_enable),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	host_model host (.clk(clk), .alert_pin(alert_pin), .sck(sck),
		.sd(host_sd));

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_errors++;
			end_of_test();
		end
	end

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m,
				got, exp);
		end
	endtask : check

	// one avalon access, held until waitrequest is sampled low at an edge
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		logic w;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// values read here are those sampled at this rising edge
		do
		begin
			@(posedge clk);
			w = avs_waitrequest;
			r = avs_readdata;
		end
		while (w !== 1'b0);
		check(w, 0, "bus wait low");
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// one idle edge before any next request
		@(posedge clk);
	endtask : bus

	// register bus map, read only and unmapped places
	task automatic t_bus();
		bus(0, 4'h4, 0, q);
		check(q, 32'h200, "state reset");
		bus(0, 4'h8, 0, q);
		check(q, 0, "unmapped read");
		bus(1, 4'h4, 32'hff, q);
		bus(0, 4'h4, 0, q);
		check(q, 32'h200, "state read only");
		bus(1, 4'h0, 32'h3, q);
		bus(0, 4'h0, 0, q);
		check(q, 32'h3, "ctrl write");
	endtask : t_bus

	// frame ignored while the device drives the feedback pin
	task automatic t_blocked();
		host.frame(32'h4a02, 16, 0, q);
		bus(0, 4'h4, 0, q);
		check(q, 32'h0, "driven pin blocks");
		bus(1, 4'h0, 32'h1, q);
		check(motor_enable, 1, "motor runs");
	endtask : t_blocked

	// only status commands while serial enable is 0
	task automatic t_guard();
		host.frame(32'h5203_1234, 32, 0, q);
		check(motor_enable, 1, "no mode change");
		bus(0, 4'h4, 0, q);
		check(q, 32'h200, "ignored code");
	endtask : t_guard

	// status write enters and keeps serial mode
	task automatic t_enter();
		host.frame(32'h4a02, 16, 0, q);
		check(motor_enable, 0, "motor stopped");
		check(fb_oe, 0, "pin floats");
		bus(0, 4'h4, 0, q);
		check(q, 32'h302, "serial stays");
	endtask : t_enter

	// register write and read back, unknown code, status read
	task automatic t_regs();
		host.frame(32'h5203_a5c3, 32, 0, q);
		host.frame(32'h4b, 8, 0, q);
		host.frame(32'h5103, 16, 16, q);
		check(q[15:0], 16'ha5c3, "reg read");
		host.frame(32'h5120, 16, 16, q);
		check(q[15:0], 16'h0, "address beyond file");
		host.frame(32'h49, 8, 8, q);
		check(q[7:0], 8'h02, "status read");
	endtask : t_regs

	// store to memory, clear the register, load it back
	task automatic t_memory();
		host.frame(32'h4a0a, 16, 0, q);
		host.frame(32'h5a, 8, 0, q);
		repeat (100) @(posedge clk);
		host.frame(32'h4a02, 16, 0, q);
		host.frame(32'h5203_0000, 32, 0, q);
		host.frame(32'h59, 8, 0, q);
		repeat (100) @(posedge clk);
		host.frame(32'h5103, 16, 16, q);
		check(q[15:0], 16'ha5c3, "memory round trip");
	endtask : t_memory

	// clearing serial enable returns to normal mode
	task automatic t_leave();
		host.frame(32'h4a00, 16, 0, q);
		bus(0, 4'h4, 0, q);
		check(q, 32'h200, "normal again");
		check(motor_enable, 1, "motor resumes");
	endtask : t_leave

	// verdict and stop
	task automatic end_of_test();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// main sequence
	initial
	begin
		n_errors = 0;
		n_tests = 0;
		cycles = 0;
		rst = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_bus();
		t_blocked();
		t_guard();
		t_enter();
		t_regs();
		t_memory();
		t_leave();
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
